/* elps_regs.vh */
`ifndef ELPS_REGS_VH
`define ELPS_REGS_VH
// Loopback mode encodings
`define ELPS_MODE_W 2
`define ELPS_MODE_NORMAL 2'h0
`define ELPS_MODE_LOCAL 2'h1
`define ELPS_MODE_REMOTE 2'h2
`define ELPS_MODE_DIGITAL 2'h3
// Dual-rail symbol width (pos, neg)
`define ELPS_SYM_W 2
`define ELPS_SYM_POS 1
`define ELPS_SYM_NEG 0
`define ELPS_SYM_ZERO 2'h0
// Pin synchroniser depth and reset level of the sync chains
`define ELPS_SYNC_RST 3'h0
`define ELPS_SYNC_RST_HI 3'h7
// Link rates
`define ELPS_SYS_CLK_KHZ 100000
`define ELPS_E1_RATE_KHZ 2048
`endif

/* elps_sync.v */
`timescale 1ns/10ps
`include "elps_regs.vh"
// Three-stage pin synchroniser; output changes only when stages two and three agree.
module elps_sync #(
  parameter RST_HI = 0
) (
  input wire clk,
  input wire rst,
  input wire din,
  output wire dout
);
  reg [2:0] sh_q;
  reg out_q;
  assign dout = out_q;
  always @(posedge clk) begin
    if (rst) begin
      sh_q <= (RST_HI != 0) ? `ELPS_SYNC_RST_HI : `ELPS_SYNC_RST;
      out_q <= (RST_HI != 0);
    end else begin
      sh_q <= {sh_q[1:0], din};
      if (sh_q[1] == sh_q[2]) begin
        out_q <= sh_q[2];
      end
    end
  end
endmodule

/* elps_buf2.v */
`timescale 1ns/10ps
`include "elps_regs.vh"
// Two-entry buffer with valid/ready on both sides.
module elps_buf2 #(
  parameter W = 2
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem_q [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  always @(posedge clk) begin
    if (rst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= {W{1'b0}};
      mem_q[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule

/* elps_top.v */
// Function
// - Besides normal operation the path offers local, remote and digital loopback.
// - In local loopback the line receive inputs are ignored and the receiver sees only transmit.
// - In local loopback terminal transmit data still goes through shaping onto the line outputs.
// - In local loopback the symbol driven on the line outputs is also fed to the receiver.
// - In local loopback the looped data skips the line synchronisers and slicer and goes through the receive buffer to the terminal rails.
// - In remote loopback the terminal transmit rails are ignored.
// - In remote loopback line data is recovered and still presented on the terminal rails.
// - In remote loopback recovered data replaces the terminal rails at the transmit input.
// - In remote loopback the looped data is driven onto the line through the transmit outputs.
// - Transmit rails are sampled on the falling edge of the terminal transmit clock.
// - A one on the positive rail sends a positive pulse, on the negative rail a negative pulse; with both rails high the code sends only the positive pulse.
// - A positive line pulse gives a receive positive pulse, a negative one a negative pulse.
`timescale 1ns/10ps
`include "elps_regs.vh"
module elps_top (
  input wire SYS_CLK,
  input wire SYS_RST,
  input wire TERM_TX_CLOCK,
  input wire TERM_TX_POS_RAIL,
  input wire TERM_TX_NEG_RAIL,
  input wire LOCAL_LOOPBACK_SEL_N,
  input wire REMOTE_LOOPBACK_SEL_N,
  input wire DIGITAL_LOOPBACK_SEL_N,
  input wire LINE_RX_CLOCK,
  input wire LINE_RX_POS_IN,
  input wire LINE_RX_NEG_IN,
  output wire LINE_TX_POS_OUT,
  output wire LINE_TX_NEG_OUT,
  output wire TERM_RX_POS_RAIL,
  output wire TERM_RX_NEG_RAIL,
  output wire TERM_RX_STROBE,
  output wire [1:0] LOOP_MODE
);
  wire term_tx_clock_s;
  wire term_tx_pos_rail_s;
  wire term_tx_neg_rail_s;
  wire rclk_s;
  wire term_rx_pos_rail_s;
  wire term_rx_neg_rail_s;
  wire local_loopback_sel_n_n_s;
  wire rloop_n_s;
  wire dloop_n_s;

  // Link clocks idle high; their chains reset high so a release never shows an edge
  elps_sync #(.RST_HI(1)) u_s_term_tx_clock (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .din(TERM_TX_CLOCK),
    .dout(term_tx_clock_s)
  );
  elps_sync #(.RST_HI(0)) u_s_term_tx_pos_rail (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .din(TERM_TX_POS_RAIL),
    .dout(term_tx_pos_rail_s)
  );
  elps_sync #(.RST_HI(0)) u_s_term_tx_neg_rail (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .din(TERM_TX_NEG_RAIL),
    .dout(term_tx_neg_rail_s)
  );

  // Recovered clock and line symbols share one synchroniser depth
  elps_sync #(.RST_HI(1)) u_s_rclk (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .din(LINE_RX_CLOCK),
    .dout(rclk_s)
  );
  elps_sync #(.RST_HI(0)) u_s_term_rx_pos_rail (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .din(LINE_RX_POS_IN),
    .dout(term_rx_pos_rail_s)
  );
  elps_sync #(.RST_HI(0)) u_s_term_rx_neg_rail (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .din(LINE_RX_NEG_IN),
    .dout(term_rx_neg_rail_s)
  );

  // Selects reset high so an unsettled pin never starts a loopback
  elps_sync #(.RST_HI(1)) u_s_lsel (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .din(LOCAL_LOOPBACK_SEL_N),
    .dout(local_loopback_sel_n_n_s)
  );
  elps_sync #(.RST_HI(1)) u_s_rsel (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .din(REMOTE_LOOPBACK_SEL_N),
    .dout(rloop_n_s)
  );
  elps_sync #(.RST_HI(1)) u_s_dsel (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .din(DIGITAL_LOOPBACK_SEL_N),
    .dout(dloop_n_s)
  );

  // Edge detection on the synchronised link clocks
  // Only falling edges are used; the partner launches data away from them
  reg term_tx_clock_prev_q;
  reg rclk_prev_q;
  wire term_tx_clock_fall = term_tx_clock_prev_q && !term_tx_clock_s;
  wire rclk_fall = rclk_prev_q && !rclk_s;
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      term_tx_clock_prev_q <= 1'b1;
      rclk_prev_q <= 1'b1;
    end else begin
      term_tx_clock_prev_q <= term_tx_clock_s;
      rclk_prev_q <= rclk_s;
    end
  end

  // Mode decode; local wins when several selects are low
  reg [`ELPS_MODE_W-1:0] mode_q;
  reg [`ELPS_MODE_W-1:0] mode_d;
  always @* begin
    if (!local_loopback_sel_n_n_s) begin
      mode_d = `ELPS_MODE_LOCAL;
    end else if (!rloop_n_s) begin
      mode_d = `ELPS_MODE_REMOTE;
    end else if (!dloop_n_s) begin
      mode_d = `ELPS_MODE_DIGITAL;
    end else begin
      mode_d = `ELPS_MODE_NORMAL;
    end
  end
  // Registered so both path selectors switch in the same cycle
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      mode_q <= `ELPS_MODE_NORMAL;
    end else begin
      mode_q <= mode_d;
    end
  end
  assign LOOP_MODE = mode_q;

  // Transmit input stage: sample terminal rails on falling transmit clock
  // Rails share the clock's synchroniser delay, so setup and hold at the pins carry over
  reg [`ELPS_SYM_W-1:0] term_sym_q;
  reg term_stb_q;
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      term_sym_q <= `ELPS_SYM_ZERO;
      term_stb_q <= 1'b0;
    end else begin
      term_stb_q <= term_tx_clock_fall;
      if (term_tx_clock_fall) begin
        term_sym_q <= {term_tx_pos_rail_s, term_tx_neg_rail_s};
      end
    end
  end

  // Line receive slicer: sample line symbols on falling recovered clock
  // A single-cycle strobe means each line symbol is pushed exactly once
  reg [`ELPS_SYM_W-1:0] line_sym_q;
  reg line_stb_q;
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      line_sym_q <= `ELPS_SYM_ZERO;
      line_stb_q <= 1'b0;
    end else begin
      line_stb_q <= rclk_fall;
      if (rclk_fall) begin
        line_sym_q <= {term_rx_pos_rail_s, term_rx_neg_rail_s};
      end
    end
  end

  // Received word buffer in front of the receive output; a stall loses no word
  wire [`ELPS_SYM_W-1:0] rxb_data;
  wire rxb_valid;
  wire rxb_in_ready;
  reg [`ELPS_SYM_W-1:0] rx_in_data;
  reg rx_in_valid;

  // Transmit path source selection
  reg [`ELPS_SYM_W-1:0] tx_src;
  reg tx_src_stb;
  always @* begin
    case (mode_q)
      `ELPS_MODE_REMOTE: begin
        // Terminal rails are not read here, so a busy terminal cannot disturb the loop
        tx_src = rxb_data;
        tx_src_stb = rxb_valid;
      end
      `ELPS_MODE_DIGITAL: begin
        // The looped terminal word also goes on to the line, so the far end keeps a signal
        tx_src = rxb_data;
        tx_src_stb = rxb_valid;
      end
      `ELPS_MODE_LOCAL: begin
        tx_src = term_sym_q;
        tx_src_stb = term_stb_q;
      end
      default: begin
        tx_src = term_sym_q;
        tx_src_stb = term_stb_q;
      end
    endcase
  end

  // Line driver: one pulse polarity per symbol, never both
  // Both rails high is not a line symbol; the positive pulse wins
  reg tx_pos_q;
  reg tx_neg_q;
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      tx_pos_q <= 1'b0;
      tx_neg_q <= 1'b0;
    end else if (tx_src_stb) begin
      tx_pos_q <= tx_src[`ELPS_SYM_POS];
      tx_neg_q <= tx_src[`ELPS_SYM_NEG] && !tx_src[`ELPS_SYM_POS];
    end
  end
  assign LINE_TX_POS_OUT = tx_pos_q;
  assign LINE_TX_NEG_OUT = tx_neg_q;

  // Receive path source selection
  always @* begin
    case (mode_q)
      `ELPS_MODE_LOCAL: begin
        rx_in_data = {tx_pos_q, tx_neg_q};
        rx_in_valid = term_stb_q;
      end
      `ELPS_MODE_DIGITAL: begin
        rx_in_data = term_sym_q;
        rx_in_valid = term_stb_q;
      end
      default: begin
        rx_in_data = line_sym_q;
        rx_in_valid = line_stb_q;
      end
    endcase
  end

  // Local loop takes the symbol one cycle later so the driven value is looped
  reg [`ELPS_SYM_W-1:0] rx_lat_data_q;
  reg rx_lat_valid_q;
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rx_lat_data_q <= `ELPS_SYM_ZERO;
      rx_lat_valid_q <= 1'b0;
    end else begin
      rx_lat_data_q <= (mode_q == `ELPS_MODE_LOCAL) ? {tx_pos_q, tx_neg_q} : rx_in_data;
      rx_lat_valid_q <= rx_in_valid;
    end
  end
  // Local loop pushes the driven symbol itself, as the line would carry it
  reg [`ELPS_SYM_W-1:0] rx_push_data;
  always @* begin
    if (mode_q == `ELPS_MODE_LOCAL) begin
      rx_push_data = {tx_pos_q, tx_neg_q};
    end else begin
      rx_push_data = rx_lat_data_q;
    end
  end
  // Only push into a free slot; with the rail register always taking words it never stalls
  wire rx_push_valid = rx_lat_valid_q && rxb_in_ready;

  elps_buf2 #(.W(`ELPS_SYM_W)) u_rxbuf (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .in_data(rx_push_data),
    .in_valid(rx_push_valid),
    .in_ready(rxb_in_ready),
    .out_data(rxb_data),
    .out_valid(rxb_valid),
    .out_ready(1'b1)
  );

  // Receive output rails, updated per received symbol
  // The strobe lets a partner without the recovered clock find each symbol
  reg rx_pos_q;
  reg rx_neg_q;
  reg rx_stb_q;
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rx_pos_q <= 1'b0;
      rx_neg_q <= 1'b0;
      rx_stb_q <= 1'b0;
    end else begin
      rx_stb_q <= rxb_valid;
      if (rxb_valid) begin
        rx_pos_q <= rxb_data[`ELPS_SYM_POS];
        rx_neg_q <= rxb_data[`ELPS_SYM_NEG];
      end
    end
  end
  assign TERM_RX_POS_RAIL = rx_pos_q;
  assign TERM_RX_NEG_RAIL = rx_neg_q;
  assign TERM_RX_STROBE = rx_stb_q;
endmodule

/* elps_top_assertions.sv */
`timescale 1ns/10ps
module elps_chk (
  input wire SYS_CLK,
  input wire SYS_RST,
  input wire LOCAL_LOOPBACK_SEL_N,
  input wire REMOTE_LOOPBACK_SEL_N,
  input wire DIGITAL_LOOPBACK_SEL_N,
  input wire LINE_TX_POS_OUT,
  input wire LINE_TX_NEG_OUT,
  input wire TERM_RX_POS_RAIL,
  input wire TERM_RX_NEG_RAIL,
  input wire TERM_RX_STROBE,
  input wire [1:0] LOOP_MODE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // Eight stable cycles leave room for the pin synchroniser and the mode register
  a_local_sel_mode: assert property (
    !LOCAL_LOOPBACK_SEL_N [*8] |-> LOOP_MODE == 2'h1) else $error("local select ignored");
  a_remote_sel_mode: assert property (
    (LOCAL_LOOPBACK_SEL_N && !REMOTE_LOOPBACK_SEL_N) [*8] |-> LOOP_MODE == 2'h2)
    else $error("remote select ignored");
  a_digital_sel_mode: assert property (
    (LOCAL_LOOPBACK_SEL_N && REMOTE_LOOPBACK_SEL_N && !DIGITAL_LOOPBACK_SEL_N) [*8]
    |-> LOOP_MODE == 2'h3) else $error("digital select ignored");
  a_normal_sel_mode: assert property (
    (LOCAL_LOOPBACK_SEL_N && REMOTE_LOOPBACK_SEL_N && DIGITAL_LOOPBACK_SEL_N) [*8]
    |-> LOOP_MODE == 2'h0) else $error("normal mode not restored");
  a_no_dual_pulse: assert property (
    !(LINE_TX_POS_OUT && LINE_TX_NEG_OUT)) else $error("both line polarities at once");
  a_strobe_single: assert property (
    TERM_RX_STROBE |=> !TERM_RX_STROBE) else $error("receive strobe too long");
  a_rx_rail_hold: assert property (
    !TERM_RX_STROBE |-> $stable({TERM_RX_POS_RAIL, TERM_RX_NEG_RAIL}))
    else $error("receive rails moved without strobe");
  a_tx_symbol_hold: assert property (
    $changed({LINE_TX_POS_OUT, LINE_TX_NEG_OUT}) |=>
    $stable({LINE_TX_POS_OUT, LINE_TX_NEG_OUT}) [*4]) else $error("line symbol too short");
  a_local_loop_data: assert property (
    (LOOP_MODE == 2'h1 && $past(LOOP_MODE, 8) == 2'h1 && TERM_RX_STROBE)
    |-> {TERM_RX_POS_RAIL, TERM_RX_NEG_RAIL} == {LINE_TX_POS_OUT, LINE_TX_NEG_OUT})
    else $error("local loop data differs");
  a_remote_loop_data: assert property (
    (LOOP_MODE == 2'h2 && $past(LOOP_MODE, 8) == 2'h2 && TERM_RX_STROBE)
    |-> ##[0:2] {LINE_TX_POS_OUT, LINE_TX_NEG_OUT} == {TERM_RX_POS_RAIL, TERM_RX_NEG_RAIL})
    else $error("remote loop data differs");
endmodule
bind elps_top elps_chk i_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
  .LOCAL_LOOPBACK_SEL_N(LOCAL_LOOPBACK_SEL_N), .REMOTE_LOOPBACK_SEL_N(REMOTE_LOOPBACK_SEL_N),
  .DIGITAL_LOOPBACK_SEL_N(DIGITAL_LOOPBACK_SEL_N), .LINE_TX_POS_OUT(LINE_TX_POS_OUT),
  .LINE_TX_NEG_OUT(LINE_TX_NEG_OUT), .TERM_RX_POS_RAIL(TERM_RX_POS_RAIL),
  .TERM_RX_NEG_RAIL(TERM_RX_NEG_RAIL), .TERM_RX_STROBE(TERM_RX_STROBE), .LOOP_MODE(LOOP_MODE));

/* elps_sym_src.sv */
`timescale 1ns/10ps
// Far-end symbol source; link clock idles high and only runs within a frame
module elps_sym_src (
  input wire clk,
  output logic lclk,
  output logic pos,
  output logic neg
);
  initial begin
    lclk = 1'b1;
    pos = 1'b0;
    neg = 1'b0;
  end
  task automatic send(input logic [1:0] sym);
    @(posedge clk);
    {pos, neg} <= sym;
    // Three cycles of setup and four of hold give an 80 ns period back to back
    repeat (3) @(posedge clk);
    lclk <= 1'b0;
    repeat (4) @(posedge clk);
    lclk <= 1'b1;
    // Hold time over: show the inverse so a late sample cannot pass by luck
    {pos, neg} <= ~sym;
  endtask
endmodule

/* e1_loopback_path_select_tb.sv */
`timescale 1ns/10ps
module e1_loopback_path_select_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic loc_en = 1'b0;
  logic loc_val = 1'b1;
  logic rem_n = 1'b1;
  logic dig_n = 1'b1;
  tri1 loc_sel_n;
  wire term_tx_clock, term_tx_pos_rail, term_tx_neg_rail, rclk, term_rx_pos_rail, term_rx_neg_rail, ltp, ltn, rxp, rxn, rxs;
  wire [1:0] mode;
  int err_count = 0;
  int num_checks = 0;
  int stb_count = 0;
  int stb_base = 0;
  // Row: skip_tx, sel local/remote/digital, tx sym, line sym, mode, line tx, term rx
  logic [13:0] rows [0:8] = '{14'h1E49, 14'h1D86, 14'h1F08, 14'h0E5A, 14'h0D95,
    14'h1665, 14'h15AA, 14'h3AB2, 14'h0595};
  logic [13:0] r;
  assign loc_sel_n = loc_en ? loc_val : 1'bz;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (rxs) stb_count <= stb_count + 1;
  end
  elps_sym_src i_term (.clk(sys_clk), .lclk(term_tx_clock), .pos(term_tx_pos_rail), .neg(term_tx_neg_rail));
  elps_sym_src i_line (.clk(sys_clk), .lclk(rclk), .pos(term_rx_pos_rail), .neg(term_rx_neg_rail));
  elps_top i_dut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .TERM_TX_CLOCK(term_tx_clock),
    .TERM_TX_POS_RAIL(term_tx_pos_rail), .TERM_TX_NEG_RAIL(term_tx_neg_rail), .LOCAL_LOOPBACK_SEL_N(loc_sel_n),
    .REMOTE_LOOPBACK_SEL_N(rem_n), .DIGITAL_LOOPBACK_SEL_N(dig_n), .LINE_RX_CLOCK(rclk),
    .LINE_RX_POS_IN(term_rx_pos_rail), .LINE_RX_NEG_IN(term_rx_neg_rail), .LINE_TX_POS_OUT(ltp),
    .LINE_TX_NEG_OUT(ltn), .TERM_RX_POS_RAIL(rxp), .TERM_RX_NEG_RAIL(rxn),
    .TERM_RX_STROBE(rxs), .LOOP_MODE(mode));
  task automatic check(input string name, input logic [1:0] seen, input logic [1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      r = rows[i];
      loc_en <= 1'b1;
      loc_val <= r[12];
      rem_n <= r[11];
      dig_n <= r[10];
      repeat (10) @(posedge sys_clk);
      stb_base = stb_count;
      fork
        i_term.send(r[9:8]);
        i_line.send(r[7:6]);
      join
      repeat (10) @(posedge sys_clk);
      check("mode", mode, r[5:4]);
      if (!r[13]) check("line_tx", {ltp, ltn}, r[3:2]);
      check("term_rx", {rxp, rxn}, r[1:0]);
      check("strobe", 2'(stb_count - stb_base), 2'h1);
    end
    loc_en <= 1'b0;
    rem_n <= 1'b1;
    dig_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check("mode_undriven", mode, 2'h0);
    rem_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    stb_base = stb_count;
    // Back-to-back line symbols 1 then 2 while the terminal keeps sending symbol 1
    fork
      begin
        i_line.send(2'h1);
        i_line.send(2'h2);
      end
      begin
        i_term.send(2'h1);
        i_term.send(2'h1);
      end
    join
    repeat (10) @(posedge sys_clk);
    check("remote_tx", {ltp, ltn}, 2'h2);
    check("remote_rx", {rxp, rxn}, 2'h2);
    check("remote_strobes", 2'(stb_count - stb_base), 2'h2);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("rst_mode", mode, 2'h0);
    check("rst_tx", {ltp, ltn}, 2'h0);
    check("rst_rx", {rxp, rxn}, 2'h0);
    sys_rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    // Remote select stays low across the reset, so the mode returns once the chains settle
    check("rst_release_mode", mode, 2'h2);
    report_and_stop();
  end
endmodule
